//--- core/srs_pkg.sv
// Package for the switch reset sequencer: constants, states and carriers
package srs_pkg;
	localparam int unsigned CLK_MHZ            = 125;
	localparam int unsigned TRAIN_LIMIT_MS     = 20;
	localparam int unsigned RETRY_LIMIT_MS     = 100;
	localparam int unsigned TRAIN_LIMIT_CYC    = TRAIN_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int unsigned RETRY_LIMIT_CYC    = RETRY_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int unsigned SMB_SLOW_KHZ       = 100;
	localparam int unsigned SMB_FAST_KHZ       = 400;
	localparam logic [3:0]  MODE_NORMAL        = 4'h0;
	localparam logic [3:0]  MODE_NORMAL_EEPROM = 4'h1;
	localparam logic [3:0]  BOOT_MODE_RST      = 4'h0;
	localparam logic [3:0]  SLV_ADDR_RST       = 4'h0;

	typedef enum logic [3:0] {
		SRS_FUND_HOLD  = 4'b0000,
		SRS_PLL_INIT   = 4'b0001,
		SRS_TRAIN      = 4'b0010,
		SRS_SLV_SMB    = 4'b0011,
		SRS_MST_SMB    = 4'b0100,
		SRS_EE_LOAD    = 4'b0101,
		SRS_HALT       = 4'b0110,
		SRS_RUN        = 4'b0111,
		SRS_HOT_PROP   = 4'b1000,
		SRS_HOT_RESET  = 4'b1001
	} srs_state_t;

	typedef struct packed {
		logic [3:0] mode;
		logic       smb_slow;
		logic [3:0] slv_addr;
		logic       halt_pin;
	} srs_boot_t;

	typedef struct packed {
		logic warm_req;
		logic hot_req;
		logic link_down_hot_dis;
		logic hot_ee_dis;
		logic halt_clear;
		logic halt_set_by_ee;
	} srs_ctrl_t;
endpackage : srs_pkg

//--- core/srs_reset_seq.sv
// Reset sequencer for a multi-port switch: fundamental and hot reset flows
//
// Functional notes
// - Fundamental reset clears all but the boot values, and a warm reset also keeps train_late_o; hot reset keeps sticky fields.
// - Fundamental reset starts from reset pin or the warm-reset control bit.
// - Boot inputs sampled on pin release; software warm reset reuses old values.
// - Sampled four-bit mode field selects operation; 0x1 means EEPROM init.
// - Halt input during fundamental reset sets the status halt flag.
// - After PLL/SerDes start, release stacks into quasi-reset; training within 20ms.
// - Within 100ms stacks answer config requests with retry; ignore all else.
// - Master SMBus runs 100 kHz when slow input sampled high, else 400 kHz.
// - Slave SMBus released with pin address, then master, before EEPROM load.
// - EEPROM mode loads registers; error aborts, sets halt bit, records error.
// - EEPROM done flag set on completion or on error stop.
// - Halt bit holds logic in reset except SMBus, registers, retrying stacks.
// - Reset-triggering register write gets its completion before reset starts.
// - Hot reset from upstream TS1 hot reset, upstream link down, or control bit.
// - Link-down hot reset disable blocks only the link-down trigger.
// - First hot reset step: link-up downstream ports send hot reset TS1.
// - Hot reset spares PLLs, SerDes, SMBus; sticky and unlocked fields kept.
// - After hot reset, start training in quasi-reset; training within 20ms.
// - Hot reset reloads EEPROM only in EEPROM mode and when load not disabled.
// - After hot reset, halt bit holds all but SMBuses; set only by error or EEPROM.
// - Slave SMBus works through hot reset; reset registers read zero, ignore writes.
// - Mode 0x0 normal, 0x1 normal with EEPROM init, 0x2..0xF reserved.
`timescale 1ns/1ps
module srs_reset_seq
	import srs_pkg::*;
#(
	parameter int unsigned TRAIN_CYC = TRAIN_LIMIT_CYC,
	parameter int unsigned RETRY_CYC = RETRY_LIMIT_CYC,
	parameter int unsigned PORTS     = 7
) (
	input  wire logic                 clock_i,          // Core clock
	input  wire logic                 resetn_i,         // Async reset, active low
	input  wire logic                 clk_en_i,         // Freezes all state when low
	input  wire logic                 fundamental_reset_pin_n_i, // Reset pin, active low
	input  wire srs_pkg::srs_boot_t   boot_i,           // Boot configuration pins
	input  wire srs_pkg::srs_ctrl_t   ctrl_i,           // Control bits and pulses
	input  wire logic                 cfg_wr_done_i,    // Completion of trigger write sent
	input  wire logic                 pll_lock_i,       // PLL and SerDes ready
	input  wire logic                 us_ts1_hot_i,     // Upstream TS1 hot reset seen
	input  wire logic                 us_dl_down_i,     // Upstream link layer down
	input  wire logic [PORTS-1:0]     ds_link_up_i,     // Downstream link up per port
	input  wire logic                 ee_done_i,        // EEPROM load finished
	input  wire logic                 ee_err_i,         // EEPROM load error
	input  wire logic [3:0]           ee_err_code_i,    // EEPROM error detail
	output logic                      core_rst_o,       // Non-sticky logic reset
	output logic                      sticky_rst_o,     // Sticky field reset
	output logic                      pll_rst_o,        // PLL and SerDes reset
	output logic                      stack_quasi_o,    // Stacks answer config with retry
	output logic                      train_start_o,    // Link training enabled
	output logic                      slv_smb_rst_o,    // Slave SMBus reset
	output logic                      mst_smb_rst_o,    // Master SMBus reset
	output logic [3:0]                slv_smb_addr_o,   // Slave SMBus address
	output logic                      mst_smb_slow_o,   // Master SMBus 100 kHz
	output logic                      ee_load_o,        // EEPROM load running
	output logic                      eeprom_load_done_flag_o, // EEPROM done status
	output logic [3:0]                ee_err_info_o,    // Recorded EEPROM error
	output logic                      reset_hold_flag_o, // Halt bit, control register
	output logic                      halt_status_o,    // Halt pin seen, status register
	output logic [PORTS-1:0]          ds_hot_ts1_o,     // Send hot reset TS1 per port
	output logic                      smb_reg_mask_o,   // Slave SMBus reads zero
	output logic [3:0]                operating_mode_select_o, // Sampled mode
	output logic                      mode_reserved_o,  // Sampled mode is reserved
	output logic                      train_late_o,     // Training deadline missed
	output logic                      retry_ready_o     // Retry completions enabled
);
	import srs_pkg::*;

	srs_state_t  state_r, state_nxt;
	srs_boot_t   boot_r, boot_nxt;
	logic        hot_r, hot_nxt;
	logic        halt_r, halt_nxt;
	logic        hstat_r, hstat_nxt;
	logic        done_r, done_nxt;
	logic [3:0]  err_r, err_nxt;
	logic        wpend_r, wpend_nxt;
	logic        hpend_r, hpend_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [2:0]  pin_sync_r;
	logic        pin_n_r, pin_n_nxt;
	logic        ee_mode;
	logic        hot_trig;
	logic        pin_rise;

	// Three-stage synchroniser; change counts once stages two and three agree
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i)
			pin_sync_r <= 3'b000;
		else if (clk_en_i)
			pin_sync_r <= {pin_sync_r[1:0], fundamental_reset_pin_n_i};
	end

	always_comb begin
		pin_n_nxt = pin_n_r;
		if (pin_sync_r[1] == pin_sync_r[2])
			pin_n_nxt = pin_sync_r[2];
	end

	assign pin_rise = pin_n_nxt & ~pin_n_r;
	assign ee_mode  = (boot_r.mode == MODE_NORMAL_EEPROM);
	assign hot_trig = us_ts1_hot_i
		| (us_dl_down_i & ~ctrl_i.link_down_hot_dis)
		| hpend_r;

	always_comb begin
		state_nxt = state_r;
		boot_nxt  = boot_r;
		hot_nxt   = hot_r;
		halt_nxt  = halt_r;
		hstat_nxt = hstat_r;
		done_nxt  = done_r;
		err_nxt   = err_r;
		wpend_nxt = wpend_r;
		hpend_nxt = hpend_r;
		cnt_nxt   = (cnt_r == 32'hFFFF_FFFF) ? cnt_r : cnt_r + 32'h0000_0001;
		// Trigger writes are held until their completion has gone out
		if (ctrl_i.warm_req)
			wpend_nxt = 1'b1;
		if (ctrl_i.hot_req)
			hpend_nxt = 1'b1;
		if (ctrl_i.halt_clear)
			halt_nxt = 1'b0;
		if (!pin_n_r || (wpend_r && cfg_wr_done_i)) begin
			state_nxt = SRS_FUND_HOLD;
			hot_nxt   = 1'b0;
			wpend_nxt = 1'b0;
			hpend_nxt = 1'b0;
			halt_nxt  = 1'b0;
			hstat_nxt = 1'b0;
			done_nxt  = 1'b0;
			err_nxt   = 4'h0;
			cnt_nxt   = 32'h0000_0000;
		end else begin
			case (state_r)
				SRS_FUND_HOLD: begin
					state_nxt = SRS_PLL_INIT;
					cnt_nxt   = 32'h0000_0000;
				end
				SRS_PLL_INIT: begin
					if (pll_lock_i)
						state_nxt = SRS_TRAIN;
				end
				SRS_TRAIN: begin
					if (boot_r.halt_pin && !hot_r) begin
						hstat_nxt = 1'b1;
						halt_nxt  = 1'b1;
					end
					state_nxt = hot_r ? SRS_EE_LOAD : SRS_SLV_SMB;
				end
				SRS_SLV_SMB: state_nxt = SRS_MST_SMB;
				SRS_MST_SMB: state_nxt = SRS_EE_LOAD;
				SRS_EE_LOAD: begin
					if (!ee_mode || (hot_r && ctrl_i.hot_ee_dis))
						state_nxt = SRS_HALT;
					else if (ee_err_i) begin
						halt_nxt  = 1'b1;
						err_nxt   = ee_err_code_i;
						done_nxt  = 1'b1;
						state_nxt = SRS_HALT;
					end else if (ee_done_i) begin
						done_nxt  = 1'b1;
						if (ctrl_i.halt_set_by_ee)
							halt_nxt = 1'b1;
						state_nxt = SRS_HALT;
					end
				end
				SRS_HALT: begin
					if (!halt_nxt)
						state_nxt = SRS_RUN;
				end
				SRS_RUN: begin
					if (hot_trig) begin
						hpend_nxt = hpend_r & ~cfg_wr_done_i;
						if (!hpend_r || cfg_wr_done_i)
							state_nxt = SRS_HOT_PROP;
					end
				end
				SRS_HOT_PROP: state_nxt = SRS_HOT_RESET;
				SRS_HOT_RESET: begin
					hot_nxt   = 1'b1;
					done_nxt  = 1'b0;
					cnt_nxt   = 32'h0000_0000;
					if (!hot_trig)
						state_nxt = SRS_TRAIN;
				end
				default: state_nxt = SRS_FUND_HOLD;
			endcase
		end
		// Boot vector captured only on pin release; software warm reset keeps it
		if (pin_rise)
			boot_nxt = boot_i;
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_r <= SRS_FUND_HOLD;
			boot_r  <= '{mode: BOOT_MODE_RST, smb_slow: 1'b0, slv_addr: SLV_ADDR_RST,
				halt_pin: 1'b0};
			hot_r   <= 1'b0;
			halt_r  <= 1'b0;
			hstat_r <= 1'b0;
			done_r  <= 1'b0;
			err_r   <= 4'h0;
			wpend_r <= 1'b0;
			hpend_r <= 1'b0;
			cnt_r   <= 32'h0000_0000;
			pin_n_r <= 1'b0;
		end else if (clk_en_i) begin
			state_r <= state_nxt;
			boot_r  <= boot_nxt;
			hot_r   <= hot_nxt;
			halt_r  <= halt_nxt;
			hstat_r <= hstat_nxt;
			done_r  <= done_nxt;
			err_r   <= err_nxt;
			wpend_r <= wpend_nxt;
			hpend_r <= hpend_nxt;
			cnt_r   <= cnt_nxt;
			pin_n_r <= pin_n_nxt;
		end
	end

	logic fund_phase;
	logic hot_phase;
	assign fund_phase = (state_r == SRS_FUND_HOLD) || (state_r == SRS_PLL_INIT);
	assign hot_phase  = (state_r == SRS_HOT_PROP) || (state_r == SRS_HOT_RESET);

	// Output register group
	logic             core_rst_nxt, sticky_rst_nxt, pll_rst_nxt, quasi_nxt, train_nxt;
	logic             slv_rst_nxt, mst_rst_nxt, ee_load_nxt, mask_nxt, late_nxt, rdy_nxt;
	logic [PORTS-1:0] ts1_nxt;
	logic             core_rst_r, sticky_rst_r, pll_rst_r, quasi_r, train_r;
	logic             slv_rst_r, mst_rst_r, ee_load_r, mask_r, late_r, rdy_r;
	logic [PORTS-1:0] ts1_r;

	always_comb begin
		core_rst_nxt   = (state_r != SRS_RUN);
		sticky_rst_nxt = fund_phase && !hot_r;
		pll_rst_nxt    = (state_r == SRS_FUND_HOLD);
		quasi_nxt      = !fund_phase && !hot_phase && (state_r != SRS_RUN);
		train_nxt      = !fund_phase && !hot_phase;
		slv_rst_nxt    = fund_phase || (state_r == SRS_TRAIN && !hot_r);
		mst_rst_nxt    = slv_rst_nxt || (state_r == SRS_SLV_SMB);
		ee_load_nxt    = (state_r == SRS_EE_LOAD) && ee_mode
			&& !(hot_r && ctrl_i.hot_ee_dis);
		mask_nxt       = hot_phase || (hot_r && state_r != SRS_RUN);
		late_nxt       = late_r || ((cnt_r >= TRAIN_CYC) && !train_r);
		rdy_nxt        = quasi_nxt && (cnt_r < RETRY_CYC);
		if (!pin_n_r) begin
			late_nxt = 1'b0;
			rdy_nxt  = 1'b0;
		end else if (quasi_nxt) begin
			rdy_nxt = 1'b1;
		end
	end

	for (genvar p = 0; p < PORTS; p++) begin : g_ts1
		always_comb ts1_nxt[p] = hot_phase && ds_link_up_i[p];
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			core_rst_r   <= 1'b1;
			sticky_rst_r <= 1'b1;
			pll_rst_r    <= 1'b1;
			quasi_r      <= 1'b0;
			train_r      <= 1'b0;
			slv_rst_r    <= 1'b1;
			mst_rst_r    <= 1'b1;
			ee_load_r    <= 1'b0;
			mask_r       <= 1'b0;
			late_r       <= 1'b0;
			rdy_r        <= 1'b0;
			ts1_r        <= '0;
		end else if (clk_en_i) begin
			core_rst_r   <= core_rst_nxt;
			sticky_rst_r <= sticky_rst_nxt;
			pll_rst_r    <= pll_rst_nxt;
			quasi_r      <= quasi_nxt;
			train_r      <= train_nxt;
			slv_rst_r    <= slv_rst_nxt;
			mst_rst_r    <= mst_rst_nxt;
			ee_load_r    <= ee_load_nxt;
			mask_r       <= mask_nxt;
			late_r       <= late_nxt;
			rdy_r        <= rdy_nxt;
			ts1_r        <= ts1_nxt;
		end
	end

	assign core_rst_o              = core_rst_r;
	assign sticky_rst_o            = sticky_rst_r;
	assign pll_rst_o               = pll_rst_r;
	assign stack_quasi_o           = quasi_r;
	assign train_start_o           = train_r;
	assign slv_smb_rst_o           = slv_rst_r;
	assign mst_smb_rst_o           = mst_rst_r;
	assign slv_smb_addr_o          = boot_r.slv_addr;
	assign mst_smb_slow_o          = boot_r.smb_slow;
	assign ee_load_o               = ee_load_r;
	assign eeprom_load_done_flag_o = done_r;
	assign ee_err_info_o           = err_r;
	assign reset_hold_flag_o       = halt_r;
	assign halt_status_o           = hstat_r;
	assign ds_hot_ts1_o            = ts1_r;
	assign smb_reg_mask_o          = mask_r;
	assign operating_mode_select_o = boot_r.mode;
	assign mode_reserved_o         = (boot_r.mode != MODE_NORMAL)
		&& (boot_r.mode != MODE_NORMAL_EEPROM);
	assign train_late_o            = late_r;
	assign retry_ready_o           = rdy_r;
endmodule : srs_reset_seq

//--- dv/srs_reset_seq_assertions.sv
// Port checker for the switch reset sequencer
`timescale 1ns/1ps
module srs_reset_seq_assertions
	import srs_pkg::*;
#(
	parameter int unsigned PORTS = 7
) (
	input wire logic             clock_i,                   // Clock
	input wire logic             resetn_i,                  // Reset
	input wire logic             fundamental_reset_pin_n_i, // Pin
	input wire logic             ee_done_i,                 // Load end
	input wire logic             ee_err_i,                  // Load error
	input wire logic [PORTS-1:0] ds_link_up_i,              // Links
	input wire logic             core_rst_o,                // Core reset
	input wire logic             slv_smb_rst_o,             // Slave reset
	input wire logic             mst_smb_rst_o,             // Master reset
	input wire logic             ee_load_o,                 // Loading
	input wire logic             eeprom_load_done_flag_o,   // Done
	input wire logic             reset_hold_flag_o,         // Hold
	input wire logic [PORTS-1:0] ds_hot_ts1_o,              // TS1 out
	input wire logic             smb_reg_mask_o,            // Mask
	input wire logic [3:0]       operating_mode_select_o    // Mode
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	a_pin_starts_reset: assert property (
		$fell(fundamental_reset_pin_n_i) |-> ##[1:8] core_rst_o)
		else $error("pin low without core reset");
	a_slave_first: assert property ($fell(mst_smb_rst_o) |-> !$past(slv_smb_rst_o))
		else $error("master bus released before slave");
	a_load_mode_only: assert property (
		ee_load_o |-> operating_mode_select_o == MODE_NORMAL_EEPROM)
		else $error("load outside eeprom mode");
	a_load_after_smb: assert property (ee_load_o |-> !slv_smb_rst_o && !mst_smb_rst_o)
		else $error("load while bus in reset");
	a_hold_keeps_core: assert property (reset_hold_flag_o |-> core_rst_o)
		else $error("core running while held");
	a_done_on_end: assert property (
		ee_load_o && (ee_done_i || ee_err_i) |-> ##[1:3] eeprom_load_done_flag_o)
		else $error("done flag missing");
	a_err_sets_hold: assert property (ee_load_o && ee_err_i |-> ##[1:3] reset_hold_flag_o)
		else $error("error did not set hold");
	a_err_aborts: assert property (ee_load_o && ee_err_i |=> ##[0:2] !ee_load_o)
		else $error("load not aborted");
	a_ts1_up_only: assert property ((ds_hot_ts1_o & ~$past(ds_link_up_i)) == '0)
		else $error("ts1 on a down link");
	a_smb_live_mask: assert property (smb_reg_mask_o |-> !slv_smb_rst_o)
		else $error("slave bus reset while masking");
	c_load_error: cover property (ee_load_o && ee_err_i);
	c_hot_ts1: cover property ($rose(|ds_hot_ts1_o));
	c_hold_clear: cover property ($fell(reset_hold_flag_o));
endmodule : srs_reset_seq_assertions

bind srs_reset_seq srs_reset_seq_assertions #(.PORTS(PORTS)) srs_reset_seq_assertions_i (
	.clock_i(clock_i), .resetn_i(resetn_i), .ee_done_i(ee_done_i), .ee_err_i(ee_err_i),
	.fundamental_reset_pin_n_i(fundamental_reset_pin_n_i), .ds_link_up_i(ds_link_up_i),
	.core_rst_o(core_rst_o), .slv_smb_rst_o(slv_smb_rst_o), .mst_smb_rst_o(mst_smb_rst_o),
	.ee_load_o(ee_load_o), .eeprom_load_done_flag_o(eeprom_load_done_flag_o),
	.reset_hold_flag_o(reset_hold_flag_o), .ds_hot_ts1_o(ds_hot_ts1_o),
	.smb_reg_mask_o(smb_reg_mask_o), .operating_mode_select_o(operating_mode_select_o)
);

//--- dv/srs_partner.sv
// Far-side model: PLL, EEPROM source and SMBus master that clears the hold
`timescale 1ns/1ps
module srs_partner #(
	parameter int unsigned LOAD_CYC = 24
) (
	input  wire logic  clock_i,       // Clock
	input  wire logic  resetn_i,      // Reset
	input  wire logic  pll_rst_i,     // PLL held
	input  wire logic  ee_load_i,     // Load running
	input  wire logic  hold_i,        // Hold flag
	input  wire logic  fail_i,        // Make load fail
	output logic       pll_lock_o,    // PLL locked
	output logic       ee_done_o,     // Load done
	output logic       ee_err_o,      // Load error
	output logic [3:0] ee_err_code_o, // Error detail
	output logic       halt_clear_o   // Clear hold
);
	int unsigned ld_r;
	int unsigned hd_r;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ld_r <= 0;
			hd_r <= 0;
			{pll_lock_o, ee_done_o, ee_err_o, halt_clear_o} <= 4'h0;
			ee_err_code_o <= 4'h0;
		end else begin
			pll_lock_o <= !pll_rst_i;
			// Image ends well inside the load budget, one end pulse per load
			ld_r <= ee_load_i ? ld_r + 1 : 0;
			ee_done_o <= ee_load_i && ld_r == LOAD_CYC && !fail_i;
			ee_err_o <= ee_load_i && ld_r == LOAD_CYC && fail_i;
			ee_err_code_o <= (ee_load_i && ld_r == LOAD_CYC && fail_i) ? 4'h9 : 4'h0;
			// Slave bus master clears the hold bit after a while
			hd_r <= hold_i ? hd_r + 1 : 0;
			halt_clear_o <= hold_i && hd_r == 10;
		end
	end
endmodule : srs_partner

//--- dv/tb.sv
// Testbench for the switch reset sequencer
`timescale 1ns/1ps
module tb;
	import srs_pkg::*;
	logic       clock_i, resetn_i, clk_en_i, pin_n, wr_done, ts1, dl_down, fail;
	logic       pll_lock, e_done, e_err, clr, seen_ee, seen_slv, seen_hold, seen_q;
	logic       core_rst_o, pll_rst_o, slv_smb_rst_o, mst_smb_rst_o, mst_smb_slow_o;
	logic       ee_load_o, eeprom_load_done_flag_o, reset_hold_flag_o, halt_status_o;
	logic       smb_reg_mask_o, train_late_o, mode_reserved_o;
	logic       sticky_rst_o, stack_quasi_o, train_start_o, retry_ready_o;
	logic [3:0] e_code, slv_smb_addr_o, ee_err_info_o, operating_mode_select_o;
	logic [6:0] links, ds_hot_ts1_o;
	srs_boot_t  boot;
	srs_ctrl_t  ctrl, ctrl_w;
	int         n_mismatch, checks_done;

	srs_reset_seq #(.TRAIN_CYC(50), .RETRY_CYC(200)) srs_reset_seq_i (
		.clock_i, .resetn_i, .clk_en_i, .fundamental_reset_pin_n_i(pin_n), .boot_i(boot),
		.ctrl_i(ctrl_w), .cfg_wr_done_i(wr_done), .pll_lock_i(pll_lock), .us_ts1_hot_i(ts1),
		.us_dl_down_i(dl_down), .ds_link_up_i(links), .ee_done_i(e_done), .ee_err_i(e_err),
		.ee_err_code_i(e_code), .core_rst_o, .sticky_rst_o, .pll_rst_o, .stack_quasi_o,
		.train_start_o, .slv_smb_rst_o, .mst_smb_rst_o, .slv_smb_addr_o, .mst_smb_slow_o,
		.ee_load_o, .eeprom_load_done_flag_o, .ee_err_info_o, .reset_hold_flag_o,
		.halt_status_o, .ds_hot_ts1_o, .smb_reg_mask_o, .operating_mode_select_o,
		.mode_reserved_o, .train_late_o, .retry_ready_o);
	srs_partner srs_partner_i (
		.clock_i, .resetn_i, .pll_rst_i(pll_rst_o), .ee_load_i(ee_load_o),
		.hold_i(reset_hold_flag_o), .fail_i(fail), .pll_lock_o(pll_lock), .ee_done_o(e_done),
		.ee_err_o(e_err), .ee_err_code_o(e_code), .halt_clear_o(clr));

	always_comb begin
		ctrl_w = ctrl;
		ctrl_w.halt_clear = clr;
	end
	always @(posedge clock_i) begin
		seen_ee <= seen_ee | ee_load_o;
		seen_slv <= seen_slv | slv_smb_rst_o;
		seen_hold <= seen_hold | reset_hold_flag_o;
		seen_q <= seen_q | (stack_quasi_o & train_start_o & retry_ready_o);
	end
	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wait_core(input logic lvl);
		for (int i = 0; i < 3000 && core_rst_o !== lvl; i++) @(negedge clock_i);
		chk(core_rst_o, lvl);
	endtask : wait_core
	task clear_seen();
		{seen_ee, seen_slv, seen_hold, seen_q} = 4'h0;
	endtask : clear_seen
	task t_boot(input logic [3:0] m, input logic s, input logic [3:0] a, input logic h, f);
		pin_n = 1'b0;
		boot = '{m, s, a, h};
		fail = f;
		repeat (7) @(negedge clock_i);
		chk(sticky_rst_o, 1'b1);
		chk({stack_quasi_o, train_start_o, retry_ready_o}, 3'h0);
		clear_seen();
		pin_n = 1'b1;
		repeat (8) @(negedge clock_i);
		boot = ~boot;
		wait_core(1'b0);
		chk(operating_mode_select_o, m);
		chk(mode_reserved_o, m > 4'h1);
		chk(mst_smb_slow_o, s);
		chk(slv_smb_addr_o, a);
		chk(halt_status_o, h);
		chk(seen_ee, m == 4'h1);
		chk(eeprom_load_done_flag_o, m == 4'h1);
		chk(ee_err_info_o, f ? 4'h9 : 4'h0);
		chk(seen_hold, f);
		chk(train_late_o, 1'b0);
		chk(seen_q, 1'b1);
	endtask : t_boot
	task t_warm(input logic [3:0] m, input logic [3:0] a);
		ctrl.warm_req = 1'b1;
		@(negedge clock_i);
		ctrl.warm_req = 1'b0;
		repeat (6) @(negedge clock_i);
		chk(core_rst_o, 1'b0);
		wr_done = 1'b1;
		@(negedge clock_i);
		wr_done = 1'b0;
		wait_core(1'b1);
		wait_core(1'b0);
		chk(operating_mode_select_o, m);
		chk(slv_smb_addr_o, a);
	endtask : t_warm
	task t_hot(input int src, input logic dis, input logic ee_dis);
		ctrl.link_down_hot_dis = dis;
		ctrl.hot_ee_dis = ee_dis;
		clear_seen();
		ts1 = src == 0;
		dl_down = src == 1;
		ctrl.hot_req = src == 2;
		@(negedge clock_i);
		ctrl.hot_req = 1'b0;
		if (src == 2) begin
			repeat (4) @(negedge clock_i);
			chk({core_rst_o, |ds_hot_ts1_o}, 2'h0);
		end
		wr_done = src == 2;
		@(negedge clock_i);
		wr_done = 1'b0;
		for (int i = 0; i < 20 && ds_hot_ts1_o === 7'h0; i++) @(negedge clock_i);
		chk(ds_hot_ts1_o, dis ? 7'h0 : links);
		if (!dis) begin
			wait_core(1'b1);
			chk(smb_reg_mask_o, 1'b1);
			chk({sticky_rst_o, pll_rst_o}, 2'h0);
			// Frozen clock enable keeps the hot reset state after its trigger has gone
			clk_en_i = 1'b0;
			{ts1, dl_down} = 2'h0;
			repeat (10) @(negedge clock_i);
			chk(ds_hot_ts1_o, links);
			clk_en_i = 1'b1;
		end
		{ts1, dl_down} = 2'h0;
		wait_core(1'b0);
		chk(seen_slv, 1'b0);
		chk(seen_ee, !dis && !ee_dis);
		chk(seen_q, !dis);
	endtask : t_hot
	task print_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	initial begin
		#(8 * 40000);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		{clk_en_i, resetn_i, pin_n, wr_done, ts1, dl_down, fail} = 7'h40;
		{boot, ctrl} = '0;
		links = 7'h55;
		clear_seen();
		n_mismatch = 0;
		checks_done = 0;
		repeat (10) @(negedge clock_i);
		resetn_i = 1'b1;
		t_boot(4'h1, 1'b1, 4'hA, 1'b0, 1'b0);
		t_boot(4'h1, 1'b0, 4'h6, 1'b1, 1'b1);
		t_boot(4'h2, 1'b0, 4'h3, 1'b0, 1'b0);
		t_boot(4'h0, 1'b1, 4'h5, 1'b0, 1'b0);
		t_boot(4'h1, 1'b0, 4'hC, 1'b0, 1'b0);
		t_warm(4'h1, 4'hC);
		t_hot(0, 1'b0, 1'b0);
		t_hot(1, 1'b1, 1'b0);
		t_hot(1, 1'b0, 1'b1);
		links = 7'h3C;
		t_hot(2, 1'b0, 1'b0);
		print_verdict();
	end
endmodule : tb
